/* design/ncoacc_top.sv */
// Top: phase accumulator oscillator with Avalon-MM register slave
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Pulse width field gives a pulse of 2 to the field value selected-clock periods.
// - The pulse width field matters only in pulse-frequency mode, not fixed duty.
// - Clock select 11 external pin, 10 logic cell 1, 01 system clock, 00 internal osc.
// - The 20-bit accumulator reads and writes as low, high and four-bit upper bytes.
// - Reset loads step as one and clears the accumulator.
// - Clock control bits 4:2 and accumulator upper bits 7:4 read zero, ignore writes.
// - Every overflow sets a sticky flag that only a software write or reset clears.
// - Mode bit 1 is pulse-frequency mode, 0 is fixed duty cycle mode.
// - Invert bit 1 inverts the output, and the readable level is after inversion.
module ncoacc_top
	import ncoacc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Clock sources
	input wire logic ext_clock_pin,
	input wire logic logic_cell1_out,
	input wire logic internal_hf_osc,
	// Oscillator outputs
	output logic osc_out,
	output logic output_level,
	output logic overflow_flag
);
	ncoacc_ctrl_t ctrl_q, ctrl_d;
	ncoacc_clkctl_t clk_q, clk_d;
	logic [ACC_W-1:0] phase_accum_q, phase_accum_d;
	logic [STEP_W-1:0] step_value_q, step_value_d;
	logic [7:0] step_hi_buf_q, step_hi_buf_d;
	logic [2:0] src_prev_q, src_prev_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic raw_q, raw_d;
	logic lvl_q, lvl_d, out_q, out_d, ovf_q, ovf_d;
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic req, ack, tick, carry, acc_wr;
	logic [2:0] src_now;
	logic [ACC_W:0] sum;

	assign req = avs_read | avs_write;
	assign ack = req & ~wait_q;
	assign src_now = {ext_clock_pin, logic_cell1_out, internal_hf_osc};

	// Each source keeps its own history, so a select change sees only that source's edges
	always_comb begin
		unique case (clk_q.clk_src_sel)
			CKS_HFOSC: tick = src_now[0] & ~src_prev_q[0];
			CKS_SYS: tick = 1'b1;
			CKS_LC1: tick = src_now[1] & ~src_prev_q[1];
			CKS_EXT: tick = src_now[2] & ~src_prev_q[2];
		endcase
	end

	assign sum = {1'b0, phase_accum_q} + {5'h00, step_value_q};
	assign carry = ctrl_q.osc_enable & tick & sum[ACC_W];
	assign acc_wr = ack & avs_write &
		(avs_address == REG_ACC_L || avs_address == REG_ACC_H || avs_address == REG_ACC_U);

	// Register file and accumulator
	always_comb begin
		ctrl_d = ctrl_q;
		clk_d = clk_q;
		phase_accum_d = phase_accum_q;
		step_value_d = step_value_q;
		step_hi_buf_d = step_hi_buf_q;
		ovf_d = ovf_q;
		src_prev_d = src_now;
		if (ctrl_q.osc_enable && tick)
			phase_accum_d = sum[ACC_W-1:0];
		if (ack && avs_write) begin
			unique case (avs_address)
				REG_CTRL: begin
					ctrl_d.osc_enable = avs_writedata[CTRL_EN];
					ctrl_d.out_enable = avs_writedata[CTRL_OE];
					ctrl_d.output_invert = avs_writedata[CTRL_INV];
					ctrl_d.pulse_freq_mode_sel = avs_writedata[CTRL_PFM];
				end
				REG_CLK: clk_d = ncoacc_clkctl_t'({avs_writedata[7:PWS_LSB],
					avs_writedata[CKS_LSB+1:CKS_LSB]});
				REG_ACC_L: phase_accum_d[7:0] = avs_writedata[7:0];
				REG_ACC_H: phase_accum_d[15:8] = avs_writedata[7:0];
				REG_ACC_U: phase_accum_d[19:16] = avs_writedata[3:0];
				REG_STEP_L: step_value_d = {step_hi_buf_q, avs_writedata[7:0]};
				REG_STEP_H: step_hi_buf_d = avs_writedata[7:0];
				REG_STAT: if (avs_writedata[STAT_OVF])
					ovf_d = 1'b0;
			endcase
		end
		// Set after clear so an overflow in the clearing cycle is kept
		if (carry)
			ovf_d = 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= '0;
			clk_q <= '0;
			phase_accum_q <= ACC_RST;
			step_value_q <= STEP_RST;
			step_hi_buf_q <= '0;
			ovf_q <= 1'b0;
			src_prev_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			clk_q <= clk_d;
			phase_accum_q <= phase_accum_d;
			step_value_q <= step_value_d;
			step_hi_buf_q <= step_hi_buf_d;
			ovf_q <= ovf_d;
			src_prev_q <= src_prev_d;
		end
	end

	// Output stage
	always_comb begin
		cnt_d = cnt_q;
		raw_d = raw_q;
		if (!ctrl_q.osc_enable) begin
			cnt_d = '0;
			raw_d = 1'b0;
		end else if (carry) begin
			if (ctrl_q.pulse_freq_mode_sel) begin
				cnt_d = ncoacc_pulse_len(clk_q.pulse_width_sel);
				raw_d = 1'b1;
			end else begin
				raw_d = ~raw_q;
			end
		end else if (tick && ctrl_q.pulse_freq_mode_sel && cnt_q != '0) begin
			// Overlapping pulses when width exceeds overflow period are not guarded
			cnt_d = cnt_q - CNT_ONE;
			raw_d = (cnt_q != CNT_ONE);
		end
		lvl_d = raw_q ^ ctrl_q.output_invert;
		out_d = lvl_q & ctrl_q.out_enable;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			raw_q <= 1'b0;
			lvl_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			raw_q <= raw_d;
			lvl_q <= lvl_d;
			out_q <= out_d;
		end
	end

	// Bus slave: one wait cycle, then the answer
	always_comb begin
		wait_d = ~(req & wait_q);
		rdata_d = rdata_q;
		if (req && wait_q) begin
			rdata_d = '0;
			unique case (avs_address)
				REG_CTRL: begin
					rdata_d[CTRL_EN] = ctrl_q.osc_enable;
					rdata_d[CTRL_OE] = ctrl_q.out_enable;
					rdata_d[CTRL_LVL] = lvl_q;
					rdata_d[CTRL_INV] = ctrl_q.output_invert;
					rdata_d[CTRL_PFM] = ctrl_q.pulse_freq_mode_sel;
				end
				REG_CLK: rdata_d[7:0] = {clk_q.pulse_width_sel, 3'h0,
					clk_q.clk_src_sel} & CLK_WMASK;
				REG_ACC_L: rdata_d[7:0] = phase_accum_q[7:0];
				REG_ACC_H: rdata_d[7:0] = phase_accum_q[15:8];
				REG_ACC_U: rdata_d[7:0] = {4'h0, phase_accum_q[19:16]} & ACCU_WMASK;
				REG_STEP_L: rdata_d[7:0] = step_value_q[7:0];
				REG_STEP_H: rdata_d[7:0] = step_hi_buf_q;
				REG_STAT: rdata_d[STAT_OVF] = ovf_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;
	assign osc_out = out_q;
	assign output_level = lvl_q;
	assign overflow_flag = ovf_q;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_pfm_start;
		carry && ctrl_q.pulse_freq_mode_sel;
	endsequence
	sequence s_hi_write;
		ack && avs_write && avs_address == REG_STEP_H;
	endsequence

	flag_set_a: assert property (carry |=> ovf_q)
		else $error("overflow did not set flag");
	flag_hold_a: assert property (ovf_q && !(ack && avs_write && avs_address == REG_STAT)
		|=> ovf_q)
		else $error("overflow flag dropped without clear");
	pulse_len_a: assert property (s_pfm_start |=> raw_q &&
		cnt_q == (CNT_ONE << $past(clk_q.pulse_width_sel)))
		else $error("pulse length not loaded from width field");
	duty_toggle_a: assert property (carry && !ctrl_q.pulse_freq_mode_sel
		|=> raw_q != $past(raw_q))
		else $error("fixed duty output did not toggle");
	level_pol_a: assert property (##1 ctrl_q.output_invert && $stable(ctrl_q.output_invert)
		|=> lvl_q == ~$past(raw_q))
		else $error("output level not inverted");
	accum_step_a: assert property (ctrl_q.osc_enable && tick && !acc_wr
		|=> phase_accum_q == $past(sum[ACC_W-1:0]))
		else $error("accumulator did not add step");
	step_atomic_a: assert property (s_hi_write |=> step_value_q == $past(step_value_q))
		else $error("step changed on high byte write");
	no_spur_tick_a: assert property (clk_q.clk_src_sel != CKS_SYS && !acc_wr
		&& src_now == src_prev_q |=> $stable(phase_accum_q))
		else $error("accumulator stepped without source edge");
	rsvd_zero_a: assert property (req && wait_q && avs_address == REG_CLK
		|=> rdata_q[4:2] == 3'h0)
		else $error("reserved clock control bits read nonzero");
	bus_answer_a: assert property (req && wait_q |=> !wait_q ##1 wait_q)
		else $error("slave answer not one cycle");
endmodule // ncoacc_top

/* design/ncoacc_pkg.sv */
// Package: register map, field layout and types for the oscillator accumulator
package ncoacc_pkg;
	localparam int ACC_W = 20;
	localparam int STEP_W = 16;
	localparam int CNT_W = 8;
	localparam int ADDR_W = 3;
	// Register word indices (byte address is four times the index)
	localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] REG_CLK = 3'h1;
	localparam logic [ADDR_W-1:0] REG_ACC_L = 3'h2;
	localparam logic [ADDR_W-1:0] REG_ACC_H = 3'h3;
	localparam logic [ADDR_W-1:0] REG_ACC_U = 3'h4;
	localparam logic [ADDR_W-1:0] REG_STEP_L = 3'h5;
	localparam logic [ADDR_W-1:0] REG_STEP_H = 3'h6;
	localparam logic [ADDR_W-1:0] REG_STAT = 3'h7;
	// Control register fields
	localparam int CTRL_EN = 7;
	localparam int CTRL_OE = 6;
	localparam int CTRL_LVL = 5;
	localparam int CTRL_INV = 4;
	localparam int CTRL_PFM = 0;
	localparam int STAT_OVF = 0;
	// Clock control fields
	localparam int PWS_LSB = 5;
	localparam int CKS_LSB = 0;
	localparam logic [7:0] CLK_WMASK = 8'he3;
	localparam logic [7:0] ACCU_WMASK = 8'h0f;
	// Reset values and the pulse counter unit
	localparam logic [STEP_W-1:0] STEP_RST = 16'h0001;
	localparam logic [ACC_W-1:0] ACC_RST = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	// Clock source encodings
	typedef enum logic [1:0] {
		CKS_HFOSC = 2'h0,
		CKS_SYS = 2'h1,
		CKS_LC1 = 2'h2,
		CKS_EXT = 2'h3
	} ncoacc_cks_t;
	typedef struct packed {
		logic osc_enable;
		logic out_enable;
		logic output_invert;
		logic pulse_freq_mode_sel;
	} ncoacc_ctrl_t;
	typedef struct packed {
		logic [2:0] pulse_width_sel;
		ncoacc_cks_t clk_src_sel;
	} ncoacc_clkctl_t;
	// Pulse length in selected-clock periods: 2 ** field
	function automatic logic [CNT_W-1:0] ncoacc_pulse_len(input logic [2:0] pws);
		ncoacc_pulse_len = CNT_ONE << pws;
	endfunction
endpackage

/* dv/ncoacc_tb_top.sv */
// Self-checking bench for the phase accumulator oscillator
`timescale 1ns/1ps
module ncoacc_tb_top;
	import ncoacc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [2:0] src_in = 3'h0;
	logic osc_out;
	logic output_level;
	logic overflow_flag;
	logic [7:0] q;
	logic [19:0] e;
	int err_count = 0;
	int n_compared = 0;
	int n0;
	int n2;
	// Reset value rows: address beside expected read
	logic [10:0] rows [8] = '{{REG_CTRL, 8'h00}, {REG_CLK, 8'h00}, {REG_ACC_L, 8'h00},
		{REG_ACC_H, 8'h00}, {REG_ACC_U, 8'h00}, {REG_STEP_L, 8'h01}, {REG_STEP_H, 8'h00},
		{REG_STAT, 8'h00}};
	logic [1:0] srcs [3] = '{2'h0, 2'h2, 2'h3};
	int cnts [3] = '{3, 5, 7};

	always #2 sys_clk = ~sys_clk;

	ncoacc_top dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_clock_pin(src_in[2]), .logic_cell1_out(src_in[1]), .internal_hf_osc(src_in[0]),
		.osc_out(osc_out), .output_level(output_level), .overflow_flag(overflow_flag));

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] x, input logic [7:0] g);
		n_compared++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic chk1(input string nm, input logic x, input logic g);
		n_compared++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, x, g);
		end
	endtask

	// One access; an edge passes first so strobes never change twice in a step
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		int i;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i >= 50) begin
			err_count++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [2:0] a);
		bus(1'b0, a, 8'h00);
	endtask

	task automatic acc_set(input logic [19:0] v);
		wr(REG_ACC_L, v[7:0]);
		wr(REG_ACC_H, v[15:8]);
		wr(REG_ACC_U, {4'h0, v[19:16]});
	endtask

	task automatic pulse(input logic [2:0] m, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			src_in <= m;
			repeat (3) @(posedge sys_clk);
			src_in <= 3'h0;
			repeat (3) @(posedge sys_clk);
		end
	endtask

	// Ticks that the pulse stays high after the carry tick
	task automatic pfm_len(input logic [2:0] w, output int n);
		wr(REG_CTRL, 8'h00);
		acc_set(20'hfffff);
		// Width stays far below the 2^20-tick overflow period at step one
		wr(REG_CLK, {w, 5'h00});
		wr(REG_CTRL, 8'h81);
		pulse(3'h1, 1);
		chk1("pulse start", 1'b1, output_level);
		n = 0;
		while (output_level === 1'b1 && n < 20) begin
			pulse(3'h1, 1);
			n++;
		end
		// A pulse still high after the bound counts as a failure
		chk1("pulse end", 1'b0, output_level);
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (rows[k]) begin
			rd(rows[k][10:8]);
			chk8("reset value", rows[k][7:0], q);
		end
		$display("reset values done");
		wr(REG_CLK, 8'hff);
		rd(REG_CLK);
		chk8("clk ctl", 8'he3, q);
		acc_set(20'hfa55a);
		wr(REG_ACC_U, 8'hff);
		rd(REG_ACC_U);
		chk8("acc upper", 8'h0f, q);
		rd(REG_ACC_H);
		chk8("acc high", 8'ha5, q);
		rd(REG_ACC_L);
		chk8("acc low", 8'h5a, q);
		$display("loose bits done");
		wr(REG_STEP_H, 8'h80);
		rd(REG_STEP_H);
		chk8("step high", 8'h80, q);
		wr(REG_STEP_L, 8'h00);
		foreach (srcs[k]) begin
			wr(REG_CTRL, 8'h00);
			acc_set(20'h0);
			wr(REG_CLK, {6'h00, srcs[k]});
			wr(REG_CTRL, 8'h80);
			pulse(3'h7, 3);
			pulse(3'h6, 2);
			pulse(3'h4, 2);
			wr(REG_CTRL, 8'h00);
			e = 20'(cnts[k]) << 15;
			rd(REG_ACC_U);
			chk8("src acc upper", {4'h0, e[19:16]}, q);
			rd(REG_ACC_H);
			chk8("src acc high", e[15:8], q);
		end
		acc_set(20'h0);
		wr(REG_CLK, 8'h01);
		wr(REG_CTRL, 8'h80);
		// Enabled for the three edges up to the disabling write
		wr(REG_CTRL, 8'h00);
		rd(REG_ACC_U);
		chk8("sys acc upper", 8'h01, q);
		rd(REG_ACC_H);
		chk8("sys acc high", 8'h80, q);
		$display("clock sources done");
		acc_set(20'h0);
		wr(REG_CLK, 8'h00);
		wr(REG_CTRL, 8'h80);
		src_in <= 3'h4;
		repeat (4) @(posedge sys_clk);
		wr(REG_CLK, 8'h03);
		repeat (4) @(posedge sys_clk);
		wr(REG_CTRL, 8'h00);
		src_in <= 3'h0;
		rd(REG_ACC_H);
		chk8("switch acc", 8'h00, q);
		$display("source switch done");
		wr(REG_STEP_H, 8'h00);
		wr(REG_STEP_L, 8'h01);
		acc_set(20'hfffff);
		wr(REG_CLK, 8'h00);
		wr(REG_CTRL, 8'h80);
		pulse(3'h1, 1);
		chk1("flag", 1'b1, overflow_flag);
		chk1("duty level", 1'b1, output_level);
		pulse(3'h1, 2);
		chk1("duty hold", 1'b1, output_level);
		wr(REG_CTRL, 8'h00);
		rd(REG_STAT);
		chk8("status", 8'h01, q);
		wr(REG_STAT, 8'h01);
		rd(REG_STAT);
		chk8("status clr", 8'h00, q);
		$display("overflow done");
		wr(REG_CTRL, 8'h50);
		rd(REG_CTRL);
		chk8("ctrl inv", 8'h70, q);
		chk1("osc out", 1'b1, osc_out);
		$display("polarity done");
		pfm_len(3'h0, n0);
		pfm_len(3'h2, n2);
		chk8("pulse span", 8'h03, 8'(n2 - n0));
		$display("pulse width done");
		// Mid-run reset while enabled with the flag set
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk1("reset flag", 1'b0, overflow_flag);
		rst <= 1'b0;
		rd(REG_CTRL);
		chk8("reset ctrl", 8'h00, q);
		rd(REG_ACC_L);
		chk8("reset acc low", 8'h00, q);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule // ncoacc_tb_top
